// ==== verilog/dfcw_interpreter.sv ====
// Purpose: Fieldbus command interpreter of a servo drive node
// Assumes: Frames arrive as one-cycle strobes from a CAN controller; tx held until accepted
// Notes:   Positioning mode selects the programmable positioning decoding of the control data
//
// Summary of operation
// - After reset the logon frame 0x81 is sent once, without data.
// - Received control data is held, not acted upon, before system start.
// - Broadcast start 0x00 with 01 00 activates the held control data.
// - Word 0x0006 moves Ready to On, 0x000F On to Operation enabled.
// - State reported at 0x180 plus node with status word and actual speed.
// - Parameter read 0x05 at 0x600 plus node, answered at 0x580 with 0x00.
// - Parameter write 0x02 stores the value and echoes number, 0x00 and value.
// - Positioning mode maps control data to flags 90-97 and variable 98.
// - Sequence program accepted only after the parameter set is stored.
// - Bit 0 enables the controller only while hardware enable is high.
// - Rising bit 2 triggers an emergency stop.
// - Bit 3 set forces an external fault.
// - Rising bit 7 clears the pending fault.
// - Bits 12 to 15 drive outputs 3 to 0 where bus-controlled.
// - Byte 2 bit 0 activates automatic mode.
// - Rising byte 2 bit 1 starts referencing in manual, program in automatic.
// - Byte 2 bit 2 aborts program and job; bit 3 holds both.
// - Byte 2 bits 6 and 7 jog positive and negative, manual only.
// - Data byte 3 drives target flags 90 to 97.
// - Data bytes 4 to 7 form variable 98, least significant byte first.
module dfcw_interpreter (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Received frames
   input wire dfcw_pkg::dfcw_frame_t i_rx_frame,
   input wire logic i_rx_valid,
   // Transmitted frames
   output dfcw_pkg::dfcw_frame_t o_tx_frame,
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   // Configuration and drive inputs
   input wire logic [6:0] i_node_id,
   input wire logic i_positioning_mode,
   input wire logic [3:0] i_bus_output_select,
   input wire logic [3:0] i_local_outputs,
   input wire logic i_hardware_enable_input,
   input wire logic [15:0] i_actual_speed,
   input wire logic i_param_set_stored,
   input wire logic i_program_load,
   // Drive state
   output logic o_started,
   output dfcw_pkg::dfcw_drive_state_t o_drive_state,
   output logic [15:0] o_speed_reference,
   output logic o_controller_enable,
   // Control word actions
   output logic o_emergency_stop,
   output logic o_external_fault_request,
   output logic o_fault_clear_request,
   output logic [3:0] o_digital_output,
   // Sequence program control
   output logic o_automatic_mode,
   output logic o_ref_run_start,
   output logic o_program_start,
   output logic o_program_abort,
   output logic o_feed_hold,
   output logic o_jog_pos,
   output logic o_jog_neg,
   output logic [7:0] o_bus_target_flags,
   output logic [31:0] o_bus_reference_variable,
   output logic o_program_accept,
   output logic o_program_reject
);

   function automatic logic [10:0] node_id(input logic [10:0] base, input logic [6:0] node);
      node_id = base + {4'h0, node};
   endfunction

   function automatic logic rising(input logic now_bit, input logic old_bit);
      rising = now_bit & ~old_bit;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Frame decode
   wire [63:0] rx_data = i_rx_frame.data;
   wire rx_is_start = i_rx_valid && i_rx_frame.id == dfcw_pkg::ID_START
      && rx_data[7:0] == dfcw_pkg::START_CMD
      && (rx_data[15:8] == 8'h00 || rx_data[15:8] == {1'b0, i_node_id});
   wire rx_is_pdo = i_rx_valid && i_rx_frame.id == node_id(dfcw_pkg::BASE_RXPDO, i_node_id);
   wire rx_is_param = i_rx_valid && i_rx_frame.id == node_id(dfcw_pkg::BASE_PARAM_REQ, i_node_id);
   wire param_read = rx_is_param && rx_data[23:16] == dfcw_pkg::PARAM_READ;
   wire param_write = rx_is_param && rx_data[23:16] == dfcw_pkg::PARAM_WRITE;
   wire [15:0] param_num = rx_data[15:0];
   wire [3:0] param_idx = param_num[3:0];

   ////////////////////////////////////////////////////////////////////////
   // Held and applied control data
   logic started_reg;
   logic [63:0] held_reg;
   logic [63:0] applied_reg;
   // Held data waits for start; afterwards each frame acts at once
   wire apply = (started_reg && rx_is_pdo) || rx_is_start;
   wire [63:0] apply_data = rx_is_pdo ? rx_data : held_reg;
   wire [15:0] new_cw = apply_data[15:0];
   wire [7:0] new_b2 = apply_data[23:16];
   wire [15:0] old_cw = applied_reg[15:0];
   wire [7:0] old_b2 = applied_reg[23:16];
   wire [7:0] app_b2 = applied_reg[23:16];
   wire pp = i_positioning_mode;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         started_reg <= 1'b0;
         held_reg <= dfcw_pkg::DATA_RESET;
         applied_reg <= dfcw_pkg::DATA_RESET;
      end else begin
         if (rx_is_start) started_reg <= 1'b1;
         if (rx_is_pdo) held_reg <= rx_data;
         if (apply) applied_reg <= apply_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Drive state machine
   dfcw_pkg::dfcw_drive_state_t state_reg, state_next;
   always_comb begin
      state_next = state_reg;
      if (apply && !pp) begin
         unique case (state_reg)
            dfcw_pkg::DFCW_READY: if (new_cw == dfcw_pkg::CW_SWITCH_ON) state_next = dfcw_pkg::DFCW_ON;
            dfcw_pkg::DFCW_ON: if (new_cw == dfcw_pkg::CW_ENABLE_OP) state_next = dfcw_pkg::DFCW_OP_ENABLED;
            dfcw_pkg::DFCW_OP_ENABLED: state_next = state_reg;
            default: state_next = dfcw_pkg::DFCW_READY;
         endcase
      end
   end

   wire [15:0] status_word = (state_reg == dfcw_pkg::DFCW_ON) ? dfcw_pkg::SW_ON
      : (state_reg == dfcw_pkg::DFCW_OP_ENABLED) ? dfcw_pkg::SW_OP_ENABLED : dfcw_pkg::SW_READY;
   // Only the assigned control bits reach the outputs
   wire [3:0] bus_outs = {applied_reg[dfcw_pkg::CW_OUT_LSB], applied_reg[dfcw_pkg::CW_OUT_LSB + 1],
      applied_reg[dfcw_pkg::CW_OUT_LSB + 2], applied_reg[dfcw_pkg::CW_OUT_LSB + 3]};
   wire enable_cmd = pp ? applied_reg[dfcw_pkg::CW_ENABLE] : (state_reg == dfcw_pkg::DFCW_OP_ENABLED);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= dfcw_pkg::DFCW_READY;
         o_speed_reference <= 16'h0000;
         o_controller_enable <= 1'b0;
         o_emergency_stop <= 1'b0;
         o_external_fault_request <= 1'b0;
         o_fault_clear_request <= 1'b0;
         o_digital_output <= 4'h0;
         o_ref_run_start <= 1'b0;
         o_program_start <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (apply && !pp) o_speed_reference <= apply_data[47:32];
         o_controller_enable <= enable_cmd & i_hardware_enable_input;
         o_emergency_stop <= apply && pp && rising(new_cw[dfcw_pkg::CW_ESTOP], old_cw[dfcw_pkg::CW_ESTOP]);
         o_external_fault_request <= pp && applied_reg[dfcw_pkg::CW_EXT_FAULT];
         o_fault_clear_request <= apply && pp
            && rising(new_cw[dfcw_pkg::CW_FAULT_CLEAR], old_cw[dfcw_pkg::CW_FAULT_CLEAR]);
         o_digital_output <= (pp ? i_bus_output_select : 4'h0) & bus_outs
            | ~(pp ? i_bus_output_select : 4'h0) & i_local_outputs;
         o_ref_run_start <= apply && pp && !new_b2[dfcw_pkg::B2_AUTO]
            && rising(new_b2[dfcw_pkg::B2_START], old_b2[dfcw_pkg::B2_START]);
         o_program_start <= apply && pp && new_b2[dfcw_pkg::B2_AUTO]
            && rising(new_b2[dfcw_pkg::B2_START], old_b2[dfcw_pkg::B2_START]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequence program interface
   logic params_stored_reg;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_automatic_mode <= 1'b0;
         o_program_abort <= 1'b0;
         o_feed_hold <= 1'b0;
         o_jog_pos <= 1'b0;
         o_jog_neg <= 1'b0;
         o_bus_target_flags <= 8'h00;
         o_bus_reference_variable <= 32'h0000_0000;
         params_stored_reg <= 1'b0;
         o_program_accept <= 1'b0;
         o_program_reject <= 1'b0;
      end else begin
         o_automatic_mode <= pp && app_b2[dfcw_pkg::B2_AUTO];
         o_program_abort <= pp && app_b2[dfcw_pkg::B2_ABORT];
         o_feed_hold <= pp && app_b2[dfcw_pkg::B2_HOLD];
         o_jog_pos <= pp && !app_b2[dfcw_pkg::B2_AUTO] && app_b2[dfcw_pkg::B2_JOG_POS];
         o_jog_neg <= pp && !app_b2[dfcw_pkg::B2_AUTO] && app_b2[dfcw_pkg::B2_JOG_NEG];
         if (pp) begin
            o_bus_target_flags <= applied_reg[31:24];
            o_bus_reference_variable <= applied_reg[63:32];
         end
         if (i_param_set_stored) params_stored_reg <= 1'b1;
         o_program_accept <= i_program_load && params_stored_reg;
         o_program_reject <= i_program_load && !params_stored_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Parameter channel
   logic [31:0] param_mem [dfcw_pkg::PARAM_DEPTH];
   logic param_pending_reg;
   logic [63:0] param_reply_reg;
   wire [31:0] param_value = param_write ? rx_data[55:24] : param_mem[param_idx];

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         for (int k = 0; k < dfcw_pkg::PARAM_DEPTH; k++) param_mem[k] <= 32'h0000_0000;
         param_reply_reg <= dfcw_pkg::DATA_RESET;
      end else begin
         if (param_write) param_mem[param_idx] <= rx_data[55:24];
         if (param_read || param_write) param_reply_reg <= {8'h00, param_value, dfcw_pkg::PARAM_OK, param_num};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit arbitration: logon, parameter reply, status
   logic logon_pending_reg;
   logic status_pending_reg;
   wire tx_free = !o_tx_valid || i_tx_ready;
   wire load_logon = tx_free && logon_pending_reg;
   wire load_param = tx_free && !logon_pending_reg && param_pending_reg;
   wire load_status = tx_free && !logon_pending_reg && !param_pending_reg && status_pending_reg;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         logon_pending_reg <= 1'b1;
         param_pending_reg <= 1'b0;
         status_pending_reg <= 1'b0;
         o_tx_valid <= 1'b0;
         o_tx_frame <= '0;
         o_started <= 1'b0;
         o_drive_state <= dfcw_pkg::DFCW_READY;
      end else begin
         o_started <= started_reg;
         o_drive_state <= state_reg;
         if (load_logon) logon_pending_reg <= 1'b0;
         // New events win over the clear of the same cycle
         param_pending_reg <= (param_pending_reg && !load_param) || param_read || param_write;
         status_pending_reg <= (status_pending_reg && !load_status) || apply;
         if (load_logon) begin
            o_tx_frame <= '{dfcw_pkg::ID_LOGON, dfcw_pkg::DLC_LOGON, dfcw_pkg::DATA_RESET};
         end else if (load_param) begin
            o_tx_frame <= '{node_id(dfcw_pkg::BASE_PARAM_REPLY, i_node_id), dfcw_pkg::DLC_PARAM,
               param_reply_reg};
         end else if (load_status) begin
            o_tx_frame <= '{node_id(dfcw_pkg::BASE_TXPDO, i_node_id), dfcw_pkg::DLC_STATUS,
               {16'h0000, i_actual_speed, 16'h0000, status_word}};
         end
         if (tx_free) o_tx_valid <= load_logon || load_param || load_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic logon_seen_reg;
   always_ff @(posedge i_clk) begin
      if (i_reset) logon_seen_reg <= 1'b0;
      else if (o_tx_valid && i_tx_ready && o_tx_frame.id == dfcw_pkg::ID_LOGON) logon_seen_reg <= 1'b1;
   end

   a_logon_once: assert property (@(posedge i_clk) disable iff (i_reset)
      logon_seen_reg |-> !(o_tx_valid && o_tx_frame.id == dfcw_pkg::ID_LOGON && o_tx_frame.dlc == 4'h0
         && $past(logon_seen_reg)))
      else $error("logon frame sent twice");
   a_hold_before_start: assert property (@(posedge i_clk) disable iff (i_reset)
      (!started_reg && !rx_is_start) |=> $stable(applied_reg))
      else $error("control data acted on before start");
   a_start_applies: assert property (@(posedge i_clk) disable iff (i_reset)
      rx_is_start |=> applied_reg == $past(held_reg) && started_reg)
      else $error("start did not activate held data");
   a_state_ready_on: assert property (@(posedge i_clk) disable iff (i_reset)
      (apply && !pp && state_reg == dfcw_pkg::DFCW_READY && new_cw == 16'h0006) |=> state_reg == dfcw_pkg::DFCW_ON)
      else $error("ready to on step missing");
   a_status_sent: assert property (@(posedge i_clk) disable iff (i_reset)
      (apply && !o_tx_valid && !logon_pending_reg && !param_pending_reg) |=> ##1 (o_tx_valid
         && o_tx_frame.id == 11'h180 + {4'h0, i_node_id} && o_tx_frame.data[7:0] == $past(status_word[7:0], 1)))
      else $error("status frame not queued");
   a_param_echo: assert property (@(posedge i_clk) disable iff (i_reset)
      (param_write && !o_tx_valid && !logon_pending_reg && !param_pending_reg) |=> ##1 (o_tx_valid
         && o_tx_frame.data[15:0] == $past(param_num, 2) && o_tx_frame.data[23:16] == 8'h00
         && o_tx_frame.data[55:24] == $past(rx_data[55:24], 2)))
      else $error("parameter write not echoed");
   a_program_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      o_program_accept |-> $past(params_stored_reg) && $past(i_program_load))
      else $error("program accepted before parameter set stored");
   a_enable_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      o_controller_enable |-> $past(i_hardware_enable_input) && $past(enable_cmd))
      else $error("controller enabled without hardware enable");
   a_estop_edge: assert property (@(posedge i_clk) disable iff (i_reset)
      o_emergency_stop |-> applied_reg[2] && !$past(applied_reg[2]))
      else $error("emergency stop without rising bit");
   a_fault_clear: assert property (@(posedge i_clk) disable iff (i_reset)
      o_fault_clear_request |-> applied_reg[7] && !$past(applied_reg[7]))
      else $error("fault clear without rising bit");
   a_output_map: assert property (@(posedge i_clk) disable iff (i_reset)
      (pp && i_bus_output_select[3]) |=> o_digital_output[3] == $past(applied_reg[12]))
      else $error("output 3 not following bit 12");
   a_jog_manual: assert property (@(posedge i_clk) disable iff (i_reset)
      (o_jog_pos || o_jog_neg) |-> !$past(app_b2[0]))
      else $error("jog active in automatic mode");

endmodule // dfcw_interpreter

// ==== verilog/dfcw_pkg.sv ====
// Purpose: Shared constants and types of the fieldbus control word interpreter
// Assumes: 11-bit frame identifiers, up to eight data bytes, byte 0 in data[7:0]
// Notes:   Node number is added to the base identifiers at run time
package dfcw_pkg;

   typedef struct packed {
      logic [10:0] id;
      logic [3:0] dlc;
      logic [63:0] data;
   } dfcw_frame_t;

   typedef enum logic [1:0] {
      DFCW_READY = 2'b00,
      DFCW_ON = 2'b01,
      DFCW_OP_ENABLED = 2'b10
   } dfcw_drive_state_t;

   // Identifiers
   localparam logic [10:0] ID_LOGON = 11'h081;
   localparam logic [10:0] ID_START = 11'h000;
   localparam logic [10:0] BASE_RXPDO = 11'h200;
   localparam logic [10:0] BASE_TXPDO = 11'h180;
   localparam logic [10:0] BASE_PARAM_REQ = 11'h600;
   localparam logic [10:0] BASE_PARAM_REPLY = 11'h580;

   // Frame contents
   localparam logic [7:0] START_CMD = 8'h01;
   localparam logic [7:0] PARAM_READ = 8'h05;
   localparam logic [7:0] PARAM_WRITE = 8'h02;
   localparam logic [7:0] PARAM_OK = 8'h00;
   localparam logic [15:0] CW_SWITCH_ON = 16'h0006;
   localparam logic [15:0] CW_ENABLE_OP = 16'h000F;
   localparam logic [15:0] SW_READY = 16'h0240;
   localparam logic [15:0] SW_ON = 16'h0231;
   localparam logic [15:0] SW_OP_ENABLED = 16'h0237;
   localparam logic [3:0] DLC_LOGON = 4'h0;
   localparam logic [3:0] DLC_STATUS = 4'h6;
   localparam logic [3:0] DLC_PARAM = 4'h8;

   // Control word bit positions
   localparam int CW_ENABLE = 0;
   localparam int CW_ESTOP = 2;
   localparam int CW_EXT_FAULT = 3;
   localparam int CW_FAULT_CLEAR = 7;
   localparam int CW_OUT_LSB = 12;
   // Data byte 2 bit positions
   localparam int B2_AUTO = 0;
   localparam int B2_START = 1;
   localparam int B2_ABORT = 2;
   localparam int B2_HOLD = 3;
   localparam int B2_JOG_POS = 6;
   localparam int B2_JOG_NEG = 7;

   localparam int PARAM_DEPTH = 16;
   localparam logic [63:0] DATA_RESET = 64'h0000_0000_0000_0000;

endpackage : dfcw_pkg

// ==== verification/dfcw_master_model.sv ====
// Purpose: Bus master and CAN controller stand-in facing the control word interpreter
// Assumes: Caller enters send just after a rising edge; one frame per call
// Notes:   Slow mode grants transmit ready only one cycle in eight
module dfcw_master_model (
   // Clock
   input wire logic i_clk,
   // Frames towards the node
   output dfcw_pkg::dfcw_frame_t o_rx_frame,
   output logic o_rx_valid,
   // Frames from the node
   input wire dfcw_pkg::dfcw_frame_t i_tx_frame,
   input wire logic i_tx_valid,
   output logic o_tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   logic slow = 1'b0;
   logic [2:0] tick_reg = 3'h0;
   dfcw_pkg::dfcw_frame_t got[$];

   initial begin
      o_rx_valid = 1'b0;
      o_rx_frame = '1;
      o_tx_ready = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit side, frame taken where valid and ready meet
   always @(posedge i_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         got.push_back(i_tx_frame);
      end
      tick_reg <= tick_reg + 3'h1;
      #1 o_tx_ready = !slow || (tick_reg == 3'h0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive side, strobe for exactly one clock
   task automatic send(input logic [10:0] fid, input logic [3:0] fdlc, input logic [63:0] fdata);
      o_rx_frame = '{id: fid, dlc: fdlc, data: fdata};
      o_rx_valid = 1'b1;
      @(posedge i_clk);
      #1;
      o_rx_valid = 1'b0;
      // Released lines must not keep the last value
      o_rx_frame = ~o_rx_frame;
   endtask
endmodule // dfcw_master_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench of the fieldbus control word interpreter
// Assumes: Node number 1, local output pattern 0101
// Notes:   Inputs change 1 ns after the rising edge
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic reset = 1'b1;
   logic pos_mode = 1'b0;
   logic [3:0] out_sel = 4'hF;
   logic hw_en = 1'b1;
   logic stored = 1'b0;
   logic load = 1'b0;
   logic [15:0] speed = 16'h0000;
   dfcw_pkg::dfcw_frame_t rx_frame;
   dfcw_pkg::dfcw_frame_t tx_frame;
   logic rx_valid, tx_valid, tx_ready, started, ctl_en, estop, ext_flt, flt_clr;
   logic auto_m, ref_run, prog_start, abort_j, hold, jog_p, jog_n, accept, reject;
   dfcw_pkg::dfcw_drive_state_t dstate;
   logic [15:0] speed_ref;
   logic [3:0] dout;
   logic [7:0] flags;
   logic [31:0] var98;
   int num_errors = 0;
   int total_checks = 0;

   initial begin
      forever #4 clk = ~clk;
   end

   dfcw_master_model u_master (.i_clk(clk), .o_rx_frame(rx_frame), .o_rx_valid(rx_valid),
      .i_tx_frame(tx_frame), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));

   dfcw_interpreter u_dut (.i_clk(clk), .i_reset(reset), .i_rx_frame(rx_frame), .i_rx_valid(rx_valid),
      .o_tx_frame(tx_frame), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .i_node_id(7'h01),
      .i_positioning_mode(pos_mode), .i_bus_output_select(out_sel), .i_local_outputs(4'h5),
      .i_hardware_enable_input(hw_en), .i_actual_speed(speed), .i_param_set_stored(stored),
      .i_program_load(load), .o_started(started), .o_drive_state(dstate), .o_speed_reference(speed_ref),
      .o_controller_enable(ctl_en), .o_emergency_stop(estop), .o_external_fault_request(ext_flt),
      .o_fault_clear_request(flt_clr), .o_digital_output(dout), .o_automatic_mode(auto_m),
      .o_ref_run_start(ref_run), .o_program_start(prog_start), .o_program_abort(abort_j),
      .o_feed_hold(hold), .o_jog_pos(jog_p), .o_jog_neg(jog_n), .o_bus_target_flags(flags),
      .o_bus_reference_variable(var98), .o_program_accept(accept), .o_program_reject(reject));

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic check_val(input logic [63:0] act, input logic [63:0] exp);
      total_checks++;
      if (act !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, act, exp);
      end
   endtask

   task automatic check_frame(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
      dfcw_pkg::dfcw_frame_t f;
      int n;
      n = 0;
      while (u_master.got.size() == 0 && n < 100) begin
         cyc(1);
         n++;
      end
      if (n == 100) begin
         num_errors++;
         test_done();
      end else begin
         f = u_master.got.pop_front();
         total_checks++;
         if (f !== {id, dlc, data}) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, f, {id, dlc, data});
         end
      end
   endtask

   // Control frame, returns just after the edge that took it, while pulses stand
   task automatic cw(input logic [15:0] w, input logic [7:0] b2, input logic [7:0] b3, input logic [31:0] v);
      u_master.send(11'h201, 4'h8, {v, b3, b2, w});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_start();
      u_master.send(11'h201, 4'h8, 64'h0000_0000_0000_0006);
      cyc(4);
      check_val(u_master.got.size(), 0);
      check_val({started, dstate}, {1'b0, dfcw_pkg::DFCW_READY});
      u_master.send(11'h201, 4'h8, 64'h0000_0000_0000_0000);
      cyc(1);
      u_master.send(11'h000, 4'h2, 64'h0000_0000_0000_0001);
      check_frame(11'h181, 4'h6, 64'h0000_0000_0000_0240);
      check_val({started, dstate}, {1'b1, dfcw_pkg::DFCW_READY});
   endtask

   task automatic t_states();
      u_master.send(11'h201, 4'h8, 64'h0000_000A_0000_0006);
      check_frame(11'h181, 4'h6, 64'h0000_0000_0000_0231);
      speed = 16'h000A;
      u_master.send(11'h201, 4'h8, 64'h0000_000A_0000_000F);
      check_frame(11'h181, 4'h6, 64'h0000_000A_0000_0237);
      check_val({dstate, speed_ref, ctl_en}, {dfcw_pkg::DFCW_OP_ENABLED, 16'h000A, 1'b1});
      check_val(dout, 4'h5);
   endtask

   task automatic t_params();
      u_master.slow = 1'b1;
      u_master.send(11'h601, 4'h8, 64'h0000_0000_5002_0325);
      check_frame(11'h581, 4'h8, 64'h0000_0000_5000_0325);
      u_master.send(11'h601, 4'h8, 64'h00FF_FFFF_FF05_0325);
      check_frame(11'h581, 4'h8, 64'h0000_0000_5000_0325);
      u_master.slow = 1'b0;
   endtask

   task automatic t_positioning();
      pos_mode = 1'b1;
      cyc(1);
      cw(16'h3F7B, 8'h01, 8'hA5, 32'h0001_86A0);
      check_val({estop, flt_clr}, 2'b00);
      cyc(1);
      check_val({ctl_en, ext_flt, dout, auto_m}, {1'b1, 1'b1, 4'b1100, 1'b1});
      check_val({flags, var98}, {8'hA5, 32'h0001_86A0});
      hw_en = 1'b0;
      out_sel = 4'h3;
      cyc(3);
      check_val({ctl_en, dout}, {1'b0, 4'b0100});
      hw_en = 1'b1;
      out_sel = 4'hF;
      cw(16'h0084, 8'h03, 8'h00, 32'h0000_0000);
      check_val({estop, flt_clr, prog_start, ref_run}, 4'b1110);
      cyc(1);
      check_val({estop, flt_clr, ext_flt}, 3'b000);
      cw(16'h0084, 8'hCC, 8'h00, 32'h0000_0000);
      check_val({estop, flt_clr}, 2'b00);
      cyc(1);
      check_val({abort_j, hold, jog_p, jog_n, auto_m}, 5'b11110);
      cw(16'h0000, 8'hC2, 8'h00, 32'h0000_0000);
      check_val({prog_start, ref_run}, 2'b01);
      cyc(1);
      cw(16'h0000, 8'hC1, 8'h00, 32'h0000_0000);
      cyc(1);
      check_val({abort_j, hold, jog_p, jog_n, auto_m}, 5'b00001);
   endtask

   task automatic t_program();
      load = 1'b1;
      cyc(1);
      load = 1'b0;
      check_val({accept, reject}, 2'b01);
      stored = 1'b1;
      cyc(1);
      stored = 1'b0;
      load = 1'b1;
      cyc(1);
      load = 1'b0;
      check_val({accept, reject}, 2'b10);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      check_frame(11'h081, 4'h0, 64'h0000_0000_0000_0000);
      t_start();
      t_states();
      t_params();
      t_positioning();
      t_program();
      cyc(10);
      check_frame(11'h181, 4'h6, 64'h0000_000A_0000_0237);
      test_done();
   end
endmodule // tb
